// *** bench/srb_far_model.sv ***
// Model of the boot pins and the two processors' init programs.
`timescale 1ns/1ns
module srb_far_model
  import srb_pkg::*;
(
  input wire logic clock_in,
  input wire logic [3:0] mode_in,
  input wire logic [3:0] dly_in,
  input wire logic master_boot_start_in,
  input wire logic control_boot_run_in,
  input wire logic control_idle_in,
  output srb_boot_pins_t boot_pins_out,
  output logic device_init_done_out,
  output logic master_init_done_out,
  output logic control_init_done_out
);
  int cnt_q = 99;
  // Cycles since the boot program began; a larger delay gives a slow init program.
  always @(posedge clock_in) cnt_q <= #2 (master_boot_start_in ? 0 : cnt_q + 1);
  assign device_init_done_out = (cnt_q == int'(dly_in));
  assign master_init_done_out = (cnt_q == 2 * int'(dly_in));
  // Control finishes its init in the same cycle it starts running, then goes idle.
  assign control_init_done_out = control_boot_run_in && !control_idle_in;
  // Every select pin is driven to a solid level, none left floating.
  assign boot_pins_out = srb_boot_pins_t'(mode_in);
endmodule

// *** bench/srb_shared_reset_boot_properties.sv ***
// Concurrent checks on the shared reset and boot-select block.
`timescale 1ns/1ns
module srb_props
  import srb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic main_reset_pin_n_in,
  input wire logic analog_reset_pin_n_in,
  input wire srb_reset_req_t reset_req_in,
  input wire logic propagate_enable_in,
  input wire logic shared_resource_reset_n_out,
  input wire logic analog_reset_n_out,
  input wire logic master_system_reset_n_out,
  input wire logic external_peripheral_port_reset_n_out,
  input wire logic control_reset_n_out,
  input wire logic analog_bus_if_reset_n_out,
  input wire logic master_boot_start_out,
  input wire logic control_boot_run_out,
  input wire logic control_idle_out,
  input wire logic boot_mode_valid_out,
  input wire logic [MODE_W-1:0] boot_mode_out,
  input wire logic fast_flash_powerup_out,
  input wire logic loader_bus_master_out,
  input wire logic loader_slave_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // The port lives inside the master side, so it never follows the shared reset.
  AST_EPP_MASTER: assert property (
    external_peripheral_port_reset_n_out == master_system_reset_n_out) else $error("port reset off master");
  AST_MAIN_PIN: assert property (
    clk_en_in && !main_reset_pin_n_in |=> !shared_resource_reset_n_out && !analog_reset_n_out) else $error("pin");
  AST_WDOG_LOCAL: assert property (
    clk_en_in && main_reset_pin_n_in && reset_req_in[2:1] != 2'b00 && reset_req_in[4:3] == 2'b00
    |=> shared_resource_reset_n_out && !master_system_reset_n_out) else $error("watchdog reached shared side");
  AST_SW_GATE: assert property (
    clk_en_in && main_reset_pin_n_in && reset_req_in[4:3] != 2'b00
    |=> shared_resource_reset_n_out == !$past(propagate_enable_in)) else $error("propagation gate wrong");
  AST_ANALOG: assert property (
    clk_en_in && (reset_req_in.analog_bus_reset || !analog_reset_pin_n_in) |=> !analog_reset_n_out) else $error("analog");
  AST_START_HELD: assert property (
    master_boot_start_out |-> !control_reset_n_out && !boot_mode_valid_out) else $error("control free at start");
  AST_RELEASE_FIRST: assert property (
    $rose(boot_mode_valid_out) |-> $past(control_reset_n_out) && analog_bus_if_reset_n_out) else $error("order");
  AST_MODE_HOLD: assert property (
    boot_mode_valid_out && $past(boot_mode_valid_out) |-> $stable(boot_mode_out)) else $error("mode moved");
  // Fast power-up set: modes 5, 6, 7, 9, 10, 11, 13, 14 and 15.
  localparam logic [15:0] FAST_SET = 16'hEEE0;
  AST_FAST: assert property (
    boot_mode_valid_out |-> fast_flash_powerup_out == FAST_SET[boot_mode_out]) else $error("fast flash flag wrong");
  AST_LOADER: assert property (
    boot_mode_valid_out |-> loader_bus_master_out == (boot_mode_out inside {4'h9, 4'hA})
    && loader_slave_out == (boot_mode_out == 4'h2)) else $error("loader role wrong");
  AST_IDLE: assert property (
    control_idle_out |-> !control_boot_run_out && control_reset_n_out) else $error("idle while running");
endmodule

bind srb_shared_reset_boot srb_props u_props (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
  .main_reset_pin_n_in(main_reset_pin_n_in), .analog_reset_pin_n_in(analog_reset_pin_n_in),
  .reset_req_in(reset_req_in), .propagate_enable_in(propagate_enable_in),
  .shared_resource_reset_n_out(shared_resource_reset_n_out), .analog_reset_n_out(analog_reset_n_out),
  .master_system_reset_n_out(master_system_reset_n_out),
  .external_peripheral_port_reset_n_out(external_peripheral_port_reset_n_out),
  .control_reset_n_out(control_reset_n_out), .analog_bus_if_reset_n_out(analog_bus_if_reset_n_out),
  .master_boot_start_out(master_boot_start_out), .control_boot_run_out(control_boot_run_out),
  .control_idle_out(control_idle_out), .boot_mode_valid_out(boot_mode_valid_out), .boot_mode_out(boot_mode_out),
  .fast_flash_powerup_out(fast_flash_powerup_out), .loader_bus_master_out(loader_bus_master_out),
  .loader_slave_out(loader_slave_out));

// *** bench/tb.sv ***
// Self-checking testbench for the shared reset and boot-select block.
`timescale 1ns/1ns
module tb;
  import srb_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pin_n = 1'b1, apin_n = 1'b1, prop = 1'b0, qual = 1'b1, wake = 1'b0, cen = 1'b1;
  srb_reset_req_t req = '0;
  logic [3:0] mode_sel = 4'h7, dly = 4'h1;
  srb_boot_pins_t pins;
  logic dev_done, mst_done, ctl_done, shared_n, analog_n, master_n, epp_n, ctl_n, bif_n;
  logic start, run, idle, valid, fast, bmaster, slave;
  logic [MODE_W-1:0] mode;
  srb_action_t act;
  int failures = 0, num_checks = 0, cycles = 0;

  always #50 clock_in = ~clock_in;

  srb_far_model far (.clock_in(clock_in), .mode_in(mode_sel), .dly_in(dly), .master_boot_start_in(start),
    .control_boot_run_in(run), .control_idle_in(idle), .boot_pins_out(pins), .device_init_done_out(dev_done),
    .master_init_done_out(mst_done), .control_init_done_out(ctl_done));

  srb_shared_reset_boot dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(cen),
    .main_reset_pin_n_in(pin_n), .analog_reset_pin_n_in(apin_n), .reset_req_in(req), .propagate_enable_in(prop),
    .qualifying_version_in(qual), .device_init_done_in(dev_done), .master_init_done_in(mst_done),
    .control_init_done_in(ctl_done), .master_to_control_wake_interrupt_in(wake), .boot_pins_in(pins),
    .shared_resource_reset_n_out(shared_n), .analog_reset_n_out(analog_n), .master_system_reset_n_out(master_n),
    .external_peripheral_port_reset_n_out(epp_n), .control_reset_n_out(ctl_n), .analog_bus_if_reset_n_out(bif_n),
    .master_boot_start_out(start), .control_boot_run_out(run), .control_idle_out(idle),
    .boot_mode_valid_out(valid), .boot_mode_out(mode), .boot_action_out(act), .fast_flash_powerup_out(fast),
    .loader_bus_master_out(bmaster), .loader_slave_out(slave));

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hung boot sequence must still end in the report.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clock_in);
    #2;
  endtask

  function automatic srb_action_t exp_action(input logic [3:0] m, input logic q);
    case (m)
      4'h0: return ACT_PARALLEL;
      4'h1: return ACT_RAM;
      4'h2: return ACT_SERIAL_SLAVE;
      4'h3: return ACT_CAN;
      4'h4: return ACT_ENET;
      4'h6: return q ? ACT_OTP : ACT_FLASH;
      4'h9: return ACT_SSI_MASTER;
      4'hA: return ACT_I2C_MASTER;
      4'hC: return ACT_ENET_ALT;
      default: return ACT_FLASH;
    endcase
  endfunction

  // Pulse the main pin, then follow a whole boot to the sampled mode.
  task automatic t_boot(input logic [3:0] m, input logic q);
    int i;
    mode_sel = m;
    qual = q;
    pin_n = 1'b0;
    step();
    pin_n = 1'b1;
    step();
    chk({start, ctl_n, analog_n, valid}, 4'b1000);
    for (i = 0; i < 60 && valid !== 1'b1; i++) step();
    chk(mode, m);
    chk(act, exp_action(m, q));
    chk({valid, fast, bmaster, slave}, {1'b1, m inside {5, 6, 7, 9, 10, 11, 13, 14, 15}, m inside {9, 10}, m == 4'h2});
    chk({ctl_n, bif_n, idle, run}, 4'b1110);
    chk({analog_n, shared_n, master_n, epp_n}, 4'b1111);
  endtask

  // Drop the clock enable around a main-pin pulse; nothing may move while frozen.
  task automatic t_freeze();
    cen = 1'b0;
    pin_n = 1'b0;
    step();
    chk({shared_n, master_n, valid, idle}, 4'b1111);
    pin_n = 1'b1;
    cen = 1'b1;
    step();
    chk({shared_n, master_n, valid, idle}, 4'b1111);
  endtask

  // Wake the idle control side while the pins change under a held mode.
  task automatic t_wake();
    logic [3:0] m;
    m = mode;
    mode_sel = ~m;
    wake = 1'b1;
    step();
    wake = 1'b0;
    chk({idle, run, valid, 1'b0}, 4'b0110);
    step();
    step();
    chk(mode, m);
  endtask

  // One cycle of a reset request; expect {shared, analog, master, port} one cycle later.
  task automatic t_req(input srb_reset_req_t r, input logic p, input logic pn, input logic an, input logic [3:0] e);
    req = r;
    prop = p;
    pin_n = pn;
    apin_n = an;
    step();
    chk({shared_n, analog_n, master_n, epp_n}, e);
    req = '0;
    prop = 1'b0;
    pin_n = 1'b1;
    apin_n = 1'b1;
    step();
    if (e[1] === 1'b0) t_boot(4'h7, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clock_in);
    #2;
    rst_n_in = 1'b1;
    for (int m = 0; m < 16; m++) t_boot(4'(m), 1'b1);
    t_boot(4'h6, 1'b0);
    dly = 4'h5;
    t_boot(4'h5, 1'b1);
    t_wake();
    t_freeze();
    t_req(5'h00, 1'b0, 1'b0, 1'b1, 4'b0000);
    t_req(5'h10, 1'b0, 1'b1, 1'b1, 4'b1000);
    t_req(5'h10, 1'b1, 1'b1, 1'b1, 4'b0000);
    t_req(5'h08, 1'b0, 1'b1, 1'b1, 4'b1000);
    t_req(5'h08, 1'b1, 1'b1, 1'b1, 4'b0000);
    t_req(5'h04, 1'b1, 1'b1, 1'b1, 4'b1000);
    t_req(5'h02, 1'b1, 1'b1, 1'b1, 4'b1000);
    t_req(5'h01, 1'b0, 1'b1, 1'b1, 4'b1011);
    t_req(5'h00, 1'b0, 1'b1, 1'b0, 4'b1011);
    summarize();
  end
endmodule

// *** src/srb_pkg.sv ***
// Package of types and constants for the shared reset and boot-select block.
package srb_pkg;

  // Reset levels on the active-low reset outputs.
  localparam logic RESET_ON = 1'b0;
  localparam logic RESET_OFF = 1'b1;

  // Width of the boot mode number and the fixed mode numbers.
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_PARALLEL = 4'h0;
  localparam logic [3:0] MODE_RAM = 4'h1;
  localparam logic [3:0] MODE_SERIAL = 4'h2;
  localparam logic [3:0] MODE_CAN = 4'h3;
  localparam logic [3:0] MODE_ENET = 4'h4;
  localparam logic [3:0] MODE_OTP = 4'h6;
  localparam logic [3:0] MODE_FLASH = 4'h7;
  localparam logic [3:0] MODE_SSI_MASTER = 4'h9;
  localparam logic [3:0] MODE_I2C_MASTER = 4'hA;
  localparam logic [3:0] MODE_ENET_ALT = 4'hC;
  localparam logic [3:0] MODE_FAST_FLASH = 4'hF;
  // One bit per mode number: set where the fast flash power-up is used.
  localparam logic [15:0] FAST_FLASH_MASK = 16'hEEE0;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // What the master boot program does with the sampled mode.
  typedef enum logic [3:0] {
    ACT_NONE = 4'h0,
    ACT_PARALLEL = 4'h1,
    ACT_RAM = 4'h2,
    ACT_SERIAL_SLAVE = 4'h3,
    ACT_CAN = 4'h4,
    ACT_ENET = 4'h5,
    ACT_ENET_ALT = 4'h6,
    ACT_FLASH = 4'h7,
    ACT_OTP = 4'h8,
    ACT_SSI_MASTER = 4'h9,
    ACT_I2C_MASTER = 4'hA
  } srb_action_t;

  // Boot sequence states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_DEV_INIT = 3'b001,
    ST_MST_INIT = 3'b011,
    ST_RELEASE = 3'b010,
    ST_SAMPLE = 3'b110,
    ST_RUN = 3'b111
  } srb_state_t;

  // Reset requests, each active high and synchronous to the clock.
  typedef struct packed {
    logic master_software_reset;
    logic master_debugger_reset;
    logic master_watchdog_reset;
    logic master_nmi_watchdog_reset;
    logic analog_bus_reset;
  } srb_reset_req_t;

  // The four boot-select pins, most significant first.
  typedef struct packed {
    logic boot_select_bit3;
    logic boot_select_bit2;
    logic boot_select_bit1;
    logic boot_select_bit0;
  } srb_boot_pins_t;

endpackage

// *** src/srb_shared_reset_boot.sv ***
// Shared-resource reset distribution and master boot sequencing with boot-mode decode.
`timescale 1ns/1ns
module srb_shared_reset_boot
  import srb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic main_reset_pin_n_in,
  input wire logic analog_reset_pin_n_in,
  input wire srb_reset_req_t reset_req_in,
  input wire logic propagate_enable_in,
  input wire logic qualifying_version_in,
  input wire logic device_init_done_in,
  input wire logic master_init_done_in,
  input wire logic control_init_done_in,
  input wire logic master_to_control_wake_interrupt_in,
  input wire srb_boot_pins_t boot_pins_in,
  output logic shared_resource_reset_n_out,
  output logic analog_reset_n_out,
  output logic master_system_reset_n_out,
  output logic external_peripheral_port_reset_n_out,
  output logic control_reset_n_out,
  output logic analog_bus_if_reset_n_out,
  output logic master_boot_start_out,
  output logic control_boot_run_out,
  output logic control_idle_out,
  output logic boot_mode_valid_out,
  output logic [MODE_W-1:0] boot_mode_out,
  output srb_action_t boot_action_out,
  output logic fast_flash_powerup_out,
  output logic loader_bus_master_out,
  output logic loader_slave_out
);

  // All state of the block lives in this one record.
  typedef struct packed {
    // Where the master boot stands.
    srb_state_t state;
    // Active-low reset lines, one per domain.
    logic shared_n;
    logic analog_n;
    logic master_n;
    logic epp_n;
    logic control_n;
    logic bus_if_n;
    // Boot progress flags of the two processors.
    logic boot_start;
    logic control_run;
    logic control_idle;
    // The boot mode as sampled, with what it selects.
    logic mode_valid;
    logic [MODE_W-1:0] mode;
    srb_action_t action;
    logic fast_flash;
    logic bus_master;
    logic slave;
  } srb_regs_t;

  // Registered record and its next value.
  srb_regs_t state_q;
  srb_regs_t state_d;
  // Combinational request terms and the decoded pins.
  logic master_req;
  logic shared_req;
  logic analog_req;
  logic [MODE_W-1:0] pin_mode;
  srb_action_t pin_action;

  // Maps a mode number to the loader action; unsupported numbers fall to flash.
  // Flash is the starting value on purpose: any number that no branch names
  // lands on a mode that needs no external host.
  // The one-time-programmable boot hangs on the version input, so a device
  // that lacks it quietly takes the flash path instead of failing to boot.
  function automatic srb_action_t decode_mode(input logic [MODE_W-1:0] m, input logic qual);
    srb_action_t a;
    a = ACT_FLASH;
    if (m == MODE_PARALLEL) begin
      a = ACT_PARALLEL;
    end else if (m == MODE_RAM) begin
      a = ACT_RAM;
    end else if (m == MODE_SERIAL) begin
      a = ACT_SERIAL_SLAVE;
    end else if (m == MODE_CAN) begin
      a = ACT_CAN;
    end else if (m == MODE_ENET) begin
      a = ACT_ENET;
    end else if (m == MODE_OTP) begin
      a = qual ? ACT_OTP : ACT_FLASH;
    end else if (m == MODE_FLASH || m == MODE_FAST_FLASH) begin
      a = ACT_FLASH;
    end else if (m == MODE_SSI_MASTER) begin
      a = ACT_SSI_MASTER;
    end else if (m == MODE_I2C_MASTER) begin
      a = ACT_I2C_MASTER;
    end else if (m == MODE_ENET_ALT) begin
      a = ACT_ENET_ALT;
    end
    return a;
  endfunction

  // Reset request terms; the shared side sees software and debugger resets only
  // once the master processor has opened the path.
  // The watchdog requests restart the master side and hold control, its bus and
  // analog in reset; they never reach the shared memories, so messages held there survive them.
  // The analog term adds the analog-bus request and the analog pin.
  always_comb begin
    // Every master cause restarts the boot, whatever raised it.
    master_req = !main_reset_pin_n_in
      || reset_req_in.master_software_reset
      || reset_req_in.master_debugger_reset
      || reset_req_in.master_watchdog_reset
      || reset_req_in.master_nmi_watchdog_reset;
    // Only the main pin reaches the shared side unconditionally.
    shared_req = !main_reset_pin_n_in
      || (propagate_enable_in
      && (reset_req_in.master_software_reset
      || reset_req_in.master_debugger_reset));
    // Analog adds its own two sources to the shared term.
    analog_req = shared_req
      || reset_req_in.analog_bus_reset
      || !analog_reset_pin_n_in;
  end

  // Pin bit three is the top bit of the mode number.
  // The pins are read combinationally here; only the sampling state stores them,
  // so a pin that wanders during the boot never reaches the held mode.
  always_comb begin
    pin_mode = {boot_pins_in.boot_select_bit3,
                boot_pins_in.boot_select_bit2,
                boot_pins_in.boot_select_bit1,
                boot_pins_in.boot_select_bit0};
    // Decoded from the live pins; only the sampling state keeps the result.
    pin_action = decode_mode(pin_mode, qualifying_version_in);
  end

  // Next state of every register of the block.
  // Defaults keep every field as it is, so a state only names what it changes;
  // the start strobe is the one field that falls back to zero on its own.
  always_comb begin
    state_d = state_q;
    state_d.boot_start = 1'b0;
    // Reset lines are registered so each output comes from a flop; this costs
    // one cycle of latency on assertion and release, harmless at reset scale.
    state_d.shared_n = shared_req ? RESET_ON : RESET_OFF;
    state_d.master_n = master_req ? RESET_ON : RESET_OFF;
    state_d.epp_n = master_req ? RESET_ON : RESET_OFF;
    if (master_req) begin
      // Any master reset restarts the sequence and drops the held mode.
      // Control, its bus and analog are forced back into reset as well, so a
      // later boot always finds them held.
      state_d.state = ST_HOLD;
      state_d.control_n = RESET_ON;
      state_d.bus_if_n = RESET_ON;
      state_d.analog_n = RESET_ON;
      state_d.control_run = 1'b0;
      state_d.control_idle = 1'b0;
      state_d.mode_valid = 1'b0;
      state_d.mode = MODE_RESET;
      state_d.action = ACT_NONE;
      state_d.fast_flash = 1'b0;
      state_d.bus_master = 1'b0;
      state_d.slave = 1'b0;
    end else begin
      case (state_q.state)
        ST_HOLD: begin
          // Master boot program starts as the internal reset goes inactive.
          state_d.state = ST_DEV_INIT;
          state_d.boot_start = 1'b1;
        end
        ST_DEV_INIT: begin
          // Device-level set-up by the master boot program; wait for its done flag.
          if (device_init_done_in) begin
            state_d.state = ST_MST_INIT;
          end
        end
        ST_MST_INIT: begin
          // Master subsystem set-up comes only after the device-level step.
          if (master_init_done_in) begin
            state_d.state = ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // Control side and the analog bus interface leave reset here; analog
          // follows through the analog term below once nothing else holds it.
          state_d.control_n = RESET_OFF;
          state_d.bus_if_n = RESET_OFF;
          state_d.control_run = 1'b1;
          state_d.state = ST_SAMPLE;
        end
        ST_SAMPLE: begin
          // Pins are read once here; later pin changes are ignored.
          // Role flags follow the decoded action so the loaders never disagree.
          state_d.mode = pin_mode;
          state_d.action = pin_action;
          state_d.fast_flash = FAST_FLASH_MASK[pin_mode];
          state_d.bus_master = (pin_action == ACT_SSI_MASTER)
            || (pin_action == ACT_I2C_MASTER);
          state_d.slave = (pin_action == ACT_SERIAL_SLAVE);
          state_d.mode_valid = 1'b1;
          state_d.state = ST_RUN;
        end
        ST_RUN: begin
          // Parked until the next master reset; nothing here reads the pins.
          state_d.state = ST_RUN;
        end
        default: begin
          // Unused codes fall back to the start of the sequence.
          state_d.state = ST_HOLD;
        end
      endcase
      // Analog stays held until released, and obeys its own reset sources after.
      // It reads the next bus-interface value so analog and its bus leave reset
      // in the same cycle rather than one apart.
      if (analog_req || !state_d.bus_if_n) begin
        state_d.analog_n = RESET_ON;
      end else begin
        state_d.analog_n = RESET_OFF;
      end
      // Control boot runs beside the master boot, then parks in idle.
      // A wake request only counts while idle; one that arrives early is lost,
      // so the master side must wait for idle before it wakes the control side.
      if (state_q.control_run && !state_q.control_idle && control_init_done_in) begin
        state_d.control_run = 1'b0;
        state_d.control_idle = 1'b1;
      end else if (state_q.control_idle && master_to_control_wake_interrupt_in) begin
        state_d.control_idle = 1'b0;
        state_d.control_run = 1'b1;
      end
    end
  end

  // Single register stage; the clock enable freezes all of it.
  // A low enable also holds the start strobe, so a frozen cycle never loses
  // or repeats the pulse. The asynchronous reset loads only constants.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q.state <= ST_HOLD;
      state_q.shared_n <= RESET_ON;
      state_q.analog_n <= RESET_ON;
      state_q.master_n <= RESET_ON;
      state_q.epp_n <= RESET_ON;
      state_q.control_n <= RESET_ON;
      state_q.bus_if_n <= RESET_ON;
      state_q.boot_start <= 1'b0;
      state_q.control_run <= 1'b0;
      state_q.control_idle <= 1'b0;
      state_q.mode_valid <= 1'b0;
      state_q.mode <= MODE_RESET;
      state_q.action <= ACT_NONE;
      state_q.fast_flash <= 1'b0;
      state_q.bus_master <= 1'b0;
      state_q.slave <= 1'b0;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  // Reset lines to each domain, straight from the register record.
  assign shared_resource_reset_n_out = state_q.shared_n;
  assign analog_reset_n_out = state_q.analog_n;
  assign master_system_reset_n_out = state_q.master_n;
  assign external_peripheral_port_reset_n_out = state_q.epp_n;
  assign control_reset_n_out = state_q.control_n;
  assign analog_bus_if_reset_n_out = state_q.bus_if_n;

  // Boot progress of both processors.
  assign master_boot_start_out = state_q.boot_start;
  assign control_boot_run_out = state_q.control_run;
  assign control_idle_out = state_q.control_idle;

  // The held boot mode and what it selects.
  assign boot_mode_valid_out = state_q.mode_valid;
  assign boot_mode_out = state_q.mode;
  assign boot_action_out = state_q.action;
  assign fast_flash_powerup_out = state_q.fast_flash;
  assign loader_bus_master_out = state_q.bus_master;
  assign loader_slave_out = state_q.slave;

endmodule
